// ### cbc_bus_control.sv
`timescale 1ns/1ps
`include "cbc_defines.svh"

// Function
// - Block-fetch flag only on cache-miss four-word reads
// - Every icache miss; dcache miss only if refill4
// - Same-page flag on back-to-back writes, same page
// - Read indicator active through each read
// - Write indicator active through each write
// - Write ack advances datum or ends cycle
// - Read ack lets core consume the data
// - Latch enable captures bus into read buffer
// - Reference clock out; bus logic steps on it
// - Request from master releases bus outputs
// - Grant asserted once bus is released
// - Early grant negation, wait for request drop
// - Mode bits pick condition input or strobe
// - Pin three feeds condition input three
// - Pin two feeds condition input two
// - Condition inputs pass through a synchroniser
// - Transfer-phase strobe in second cycle, per config
// - Stretched enable holds half cycle after indicator
// - Active-low strobe pulses per datum, per config
// - Data refill one or four words, icache four
module cbc_bus_control (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_icache_miss,
   input wire logic req_dcache_miss,
   input wire logic [`CBC_ADDR_W-1:0] req_addr,
   input wire cbc_pkg::cbc_cnt_t req_narrow_cnt,
   output logic req_taken,
   output logic xfer_done,
   output logic [`CBC_DATA_W-1:0] read_buffer_data,
   output logic read_buffer_valid,
   input wire logic cfg_dcache_refill4,
   input wire logic cfg_early_reclaim_en,
   input wire logic core_reclaim,
   input wire logic cfg_pin3_strobe_mode,
   input wire logic cfg_pin2_strobe_mode,
   input wire logic cfg_io_strobe_rd,
   input wire logic cfg_io_strobe_wr,
   input wire logic cfg_ext_en_rd,
   input wire logic cfg_ext_en_wr,
   input wire logic cfg_mem_strobe_rd,
   input wire logic cfg_mem_strobe_wr,
   input wire logic ack,
   input wire logic read_buffer_latch_enable,
   input wire logic [`CBC_DATA_W-1:0] ad_in,
   input wire logic external_master_request,
   output logic external_master_grant,
   output logic bus_out_en,
   output logic system_reference_clock,
   output logic rd_n,
   output logic wr_n,
   output logic burst_near_n,
   output logic per_datum_strobe_n,
   input wire logic cond_input_three_in,
   output logic cond_input_three_out,
   output logic cond_input_three_oe,
   input wire logic cond_input_two_in,
   output logic cond_input_two_out,
   output logic cond_input_two_oe,
   output logic [3:2] coprocessor_condition
);
   import cbc_pkg::*;

   function automatic logic dir_sel(input logic is_wr, input logic en_rd, input logic en_wr);
      dir_sel = is_wr ? en_wr : en_rd;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reference clock divider

   logic system_reference_clock_reg;
   logic system_reference_clock_next;
   logic tick;

   always_comb begin
      system_reference_clock_next = ~system_reference_clock_reg;
   end

   // Bus state only moves at the rising edge of the reference clock
   assign tick = ~system_reference_clock_reg;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         system_reference_clock_reg <= 1'b0;
      end else begin
         system_reference_clock_reg <= system_reference_clock_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer and arbitration state

   cbc_state_t state_reg;
   cbc_state_t state_next;
   logic is_wr_reg;
   logic is_wr_next;
   cbc_cnt_t cnt_reg;
   cbc_cnt_t cnt_next;
   logic [`CBC_ADDR_W-1:0] last_wr_addr_reg;
   logic [`CBC_ADDR_W-1:0] last_wr_addr_next;
   logic last_was_wr_reg;
   logic last_was_wr_next;
   logic flag_reg;
   logic flag_next;
   logic second_reg;
   logic second_next;
   logic gap_reg;
   logic gap_next;
   logic taken_next;
   logic done_next;
   logic block_fetch;
   logic same_page;

   always_comb begin
      // Refill size only matters for data misses; icache is always four
      block_fetch = ~req_write &
                    (req_icache_miss | (req_dcache_miss & cfg_dcache_refill4));
      same_page = req_write & last_was_wr_reg &
                  (req_addr[`CBC_ADDR_W-1:`CBC_PAGE_LSB] ==
                   last_wr_addr_reg[`CBC_ADDR_W-1:`CBC_PAGE_LSB]);
      state_next = state_reg;
      is_wr_next = is_wr_reg;
      cnt_next = cnt_reg;
      last_wr_addr_next = last_wr_addr_reg;
      last_was_wr_next = last_was_wr_reg;
      flag_next = flag_reg;
      second_next = second_reg;
      gap_next = 1'b0;
      taken_next = 1'b0;
      done_next = 1'b0;
      if (tick) begin
         unique case (state_reg)
            CBC_IDLE: begin
               if (external_master_request) begin
                  state_next = CBC_GRANTED;
               end else if (req_valid) begin
                  state_next = CBC_ADDR;
                  taken_next = 1'b1;
                  is_wr_next = req_write;
                  flag_next = req_write ? same_page : block_fetch;
                  if (req_write) begin
                     cnt_next = req_narrow_cnt;
                     last_wr_addr_next = req_addr;
                  end else begin
                     cnt_next = block_fetch ? `CBC_CNT_BLOCK : req_narrow_cnt;
                  end
                  last_was_wr_next = req_write;
               end
            end
            CBC_ADDR: begin
               state_next = CBC_DATA;
               second_next = 1'b1;
            end
            CBC_DATA: begin
               second_next = 1'b0;
               if (ack) begin
                  if (cnt_reg != `CBC_CNT_SINGLE) begin
                     cnt_next = cnt_reg - 2'h1;
                     gap_next = 1'b1;
                  end else begin
                     state_next = CBC_IDLE;
                     done_next = 1'b1;
                     flag_next = 1'b0;
                  end
               end
               // No ack: stay here, each reference cycle is a wait
            end
            CBC_GRANTED: begin
               if (!external_master_request) begin
                  state_next = CBC_IDLE;
               end else if (cfg_early_reclaim_en && core_reclaim) begin
                  state_next = CBC_RECLAIM;
               end
            end
            CBC_RECLAIM: begin
               // Bus stays released until the master lets go
               if (!external_master_request) begin
                  state_next = CBC_IDLE;
               end
            end
         endcase
      end else begin
         // Mini-burst gap spans one full reference cycle
         gap_next = gap_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg <= CBC_IDLE;
         is_wr_reg <= 1'b0;
         cnt_reg <= `CBC_CNT_SINGLE;
         last_wr_addr_reg <= `CBC_ADDR_RST;
         last_was_wr_reg <= 1'b0;
         flag_reg <= 1'b0;
         second_reg <= 1'b0;
         gap_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         is_wr_reg <= is_wr_next;
         cnt_reg <= cnt_next;
         last_wr_addr_reg <= last_wr_addr_next;
         last_was_wr_reg <= last_was_wr_next;
         flag_reg <= flag_next;
         second_reg <= second_next;
         gap_reg <= gap_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus control outputs

   logic in_xfer_next;
   logic rd_act_next;
   logic wr_act_next;
   logic rd_n_next;
   logic wr_n_next;
   logic burst_near_n_next;
   logic mem_n_next;
   logic io_next;
   logic ext_next;
   logic grant_next;
   logic oe_next;
   logic io_reg;
   logic ext_reg;

   always_comb begin
      in_xfer_next = (state_next == CBC_ADDR) | (state_next == CBC_DATA);
      rd_act_next = in_xfer_next & ~is_wr_next;
      wr_act_next = in_xfer_next & is_wr_next;
      rd_n_next = ~rd_act_next;
      wr_n_next = ~wr_act_next;
      burst_near_n_next = ~(in_xfer_next & flag_next);
      mem_n_next = ~((state_next == CBC_DATA) & ~gap_next &
                     dir_sel(is_wr_next, cfg_mem_strobe_rd, cfg_mem_strobe_wr));
      io_next = second_next & (state_next == CBC_DATA) &
                dir_sel(is_wr_next, cfg_io_strobe_rd, cfg_io_strobe_wr);
      // One clk_sys cycle past the indicator is half a reference cycle
      ext_next = dir_sel(is_wr_next, cfg_ext_en_rd, cfg_ext_en_wr) & in_xfer_next |
                 dir_sel(is_wr_reg, cfg_ext_en_rd, cfg_ext_en_wr) & (~rd_n | ~wr_n);
      // Grant follows the release by one clk_sys cycle, so never overlaps drive
      grant_next = (state_reg == CBC_GRANTED) & (state_next == CBC_GRANTED);
      oe_next = (state_next != CBC_GRANTED) & (state_next != CBC_RECLAIM);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         burst_near_n <= 1'b1;
         per_datum_strobe_n <= 1'b1;
         io_reg <= 1'b0;
         ext_reg <= 1'b0;
         external_master_grant <= 1'b0;
         bus_out_en <= 1'b1;
         system_reference_clock <= 1'b0;
         req_taken <= 1'b0;
         xfer_done <= 1'b0;
      end else begin
         rd_n <= rd_n_next;
         wr_n <= wr_n_next;
         burst_near_n <= burst_near_n_next;
         per_datum_strobe_n <= mem_n_next;
         io_reg <= io_next;
         ext_reg <= ext_next;
         external_master_grant <= grant_next;
         bus_out_en <= oe_next;
         system_reference_clock <= system_reference_clock_next;
         req_taken <= taken_next;
         xfer_done <= done_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read buffer capture

   logic [`CBC_DATA_W-1:0] rbuf_next;
   logic rbuf_valid_next;

   always_comb begin
      rbuf_next = read_buffer_data;
      rbuf_valid_next = 1'b0;
      if (tick && state_reg == CBC_DATA && !is_wr_reg && read_buffer_latch_enable) begin
         rbuf_next = ad_in;
         rbuf_valid_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         read_buffer_data <= `CBC_DATA_RST;
         read_buffer_valid <= 1'b0;
      end else begin
         read_buffer_data <= rbuf_next;
         read_buffer_valid <= rbuf_valid_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Multi-function pins

   logic c3_s1_reg;
   logic c3_s2_reg;
   logic c2_s1_reg;
   logic c2_s2_reg;
   logic [3:2] cond_next;
   logic p3_out_next;
   logic p2_out_next;

   always_comb begin
      // Strobe-mode pins read as false so stale levels cannot steer branches
      cond_next[3] = ~cfg_pin3_strobe_mode & c3_s2_reg;
      cond_next[2] = ~cfg_pin2_strobe_mode & c2_s2_reg;
      p3_out_next = cfg_pin3_strobe_mode & io_next;
      p2_out_next = cfg_pin2_strobe_mode & ext_next;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         c3_s1_reg <= 1'b0;
         c3_s2_reg <= 1'b0;
         c2_s1_reg <= 1'b0;
         c2_s2_reg <= 1'b0;
         coprocessor_condition <= 2'h0;
         cond_input_three_out <= 1'b0;
         cond_input_three_oe <= 1'b0;
         cond_input_two_out <= 1'b0;
         cond_input_two_oe <= 1'b0;
      end else begin
         c3_s1_reg <= cond_input_three_in;
         c3_s2_reg <= c3_s1_reg;
         c2_s1_reg <= cond_input_two_in;
         c2_s2_reg <= c2_s1_reg;
         coprocessor_condition <= cond_next;
         cond_input_three_out <= p3_out_next;
         cond_input_three_oe <= cfg_pin3_strobe_mode & oe_next;
         cond_input_two_out <= p2_out_next;
         cond_input_two_oe <= cfg_pin2_strobe_mode & oe_next;
      end
   end

endmodule

// ### cbc_defines.svh
`ifndef CBC_DEFINES_SVH
`define CBC_DEFINES_SVH

// Bus geometry
`define CBC_ADDR_W 32
`define CBC_DATA_W 32
`define CBC_PAGE_LSB 8
`define CBC_CNT_W 2

// Datum counts, stored as count minus one
`define CBC_CNT_BLOCK 2'h3
`define CBC_CNT_SINGLE 2'h0

// Reset values
`define CBC_ADDR_RST 32'h0000_0000
`define CBC_DATA_RST 32'h0000_0000

`endif

// ### cbc_pkg.sv
package cbc_pkg;

   typedef enum logic [4:0] {
      CBC_IDLE    = 5'b00001,
      CBC_ADDR    = 5'b00010,
      CBC_DATA    = 5'b00100,
      CBC_GRANTED = 5'b01000,
      CBC_RECLAIM = 5'b10000
   } cbc_state_t;

   typedef logic [1:0] cbc_cnt_t;

endpackage

// ### cbc_bus_control_asserts.sv
`timescale 1ns/1ps
`include "cbc_defines.svh"
module cbc_bus_control_asserts (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic req_icache_miss,
   input wire logic req_dcache_miss,
   input wire logic cfg_dcache_refill4,
   input wire logic cfg_pin3_strobe_mode,
   input wire logic req_taken,
   input wire logic xfer_done,
   input wire logic [`CBC_DATA_W-1:0] read_buffer_data,
   input wire logic read_buffer_valid,
   input wire logic ack,
   input wire logic read_buffer_latch_enable,
   input wire logic [`CBC_DATA_W-1:0] ad_in,
   input wire logic external_master_request,
   input wire logic external_master_grant,
   input wire logic bus_out_en,
   input wire logic system_reference_clock,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic burst_near_n,
   input wire logic cond_input_three_in,
   input wire logic [3:2] coprocessor_condition
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   // Pin must sit in input mode across the whole sync path
   sequence s_pin3_input;
      !cfg_pin3_strobe_mode [*4];
   endsequence
   a_grant_bus_free: assert property (external_master_grant |-> !bus_out_en)
      else $error("grant while bus driven");
   a_release_on_req: assert property ($fell(bus_out_en) |-> $past(external_master_request))
      else $error("bus released without request");
   // First edge after reset has no toggle history to compare against
   a_refclk_toggles: assert property ($past(rstn) |->
      system_reference_clock != $past(system_reference_clock))
      else $error("reference clock stalled");
   a_one_direction: assert property (!rd_n |-> wr_n && bus_out_en)
      else $error("read and write overlap");
   a_block_flag: assert property (req_taken && !rd_n |-> burst_near_n ==
      !($past(req_icache_miss) || $past(req_dcache_miss) && $past(cfg_dcache_refill4)))
      else $error("block flag wrong");
   a_read_end_ack: assert property ($rose(rd_n) |-> $past(ack) && xfer_done)
      else $error("read ended without ack");
   a_write_end_ack: assert property ($rose(wr_n) |-> $past(ack) && xfer_done)
      else $error("write ended without ack");
   a_latch_capture: assert property (read_buffer_valid |->
      $past(read_buffer_latch_enable) && read_buffer_data == $past(ad_in))
      else $error("read buffer capture wrong");
   a_cond_sync: assert property (s_pin3_input |->
      coprocessor_condition[3] == $past(cond_input_three_in, 3))
      else $error("condition three not synchronised");
endmodule
bind cbc_bus_control cbc_bus_control_asserts cbc_bus_control_asserts_inst (.*);

// ### cbc_mem_model.sv
`timescale 1ns/1ps
`include "cbc_defines.svh"
module cbc_mem_model #(
   parameter logic [31:0] WORD_BASE = 32'h0000_0000
) (
   input wire logic clk_sys,
   input wire logic rd_n,
   input wire logic per_datum_strobe_n,
   input wire logic [3:0] wait_cycles,
   output logic ack,
   output logic read_buffer_latch_enable,
   output logic [`CBC_DATA_W-1:0] ad_in
);
   logic [3:0] wait_cnt;
   logic [31:0] word;
   initial begin
      ack = 1'h0;
      read_buffer_latch_enable = 1'h0;
      ad_in = 32'h0;
      wait_cnt = 4'h0;
      word = WORD_BASE;
   end
   ////////////////////////////////////////
   // Falling edge: levels settle half a cycle before each tick
   always @(negedge clk_sys) begin
      if (per_datum_strobe_n) begin
         if (read_buffer_latch_enable) word <= word + 32'h1;
         ack <= 1'h0;
         read_buffer_latch_enable <= 1'h0;
         wait_cnt <= 4'h0;
         ad_in <= ~ad_in; // Idle bus keeps moving, no stale data
      end else if (wait_cnt < wait_cycles) begin
         wait_cnt <= wait_cnt + 4'h1;
         ad_in <= ~ad_in;
      end else begin
         ack <= 1'h1;
         read_buffer_latch_enable <= !rd_n;
         ad_in <= rd_n ? ~ad_in : word;
      end
   end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "cbc_defines.svh"
module testbench;
   import cbc_pkg::*;
   localparam logic [31:0] WORD_BASE = 32'hc0de_0000;
   logic clk_sys = 1'h0;
   logic rstn = 1'h0;
   logic req_valid = 1'h0, req_write = 1'h0, req_icache_miss = 1'h0, req_dcache_miss = 1'h0;
   logic [`CBC_ADDR_W-1:0] req_addr = 32'h0;
   cbc_cnt_t req_narrow_cnt = 2'h0;
   logic cfg_dcache_refill4 = 1'h0, cfg_early_reclaim_en = 1'h0, core_reclaim = 1'h0;
   logic cfg_pin3_strobe_mode = 1'h0, cfg_pin2_strobe_mode = 1'h0, cfg_io_strobe_rd = 1'h0;
   logic cfg_io_strobe_wr = 1'h0, cfg_ext_en_rd = 1'h0, cfg_ext_en_wr = 1'h0;
   logic cfg_mem_strobe_rd = 1'h1, cfg_mem_strobe_wr = 1'h1;
   logic external_master_request = 1'h0, drv3 = 1'h0, drv2 = 1'h0;
   logic [3:0] wait_cycles = 4'h0;
   logic req_taken, xfer_done, read_buffer_valid, external_master_grant, bus_out_en;
   logic system_reference_clock, rd_n, wr_n, burst_near_n, per_datum_strobe_n;
   logic cond_input_three_out, cond_input_three_oe, cond_input_two_out, cond_input_two_oe;
   logic ack, read_buffer_latch_enable, io_seen, ext_tail;
   logic [`CBC_DATA_W-1:0] read_buffer_data, ad_in, exp_word = WORD_BASE;
   logic [3:2] coprocessor_condition;
   int fail_count = 0, comparisons = 0;
   wire p3_pin = cond_input_three_oe ? cond_input_three_out : drv3;
   wire p2_pin = cond_input_two_oe ? cond_input_two_out : drv2;
   cbc_bus_control cbc_bus_control_inst (
      .cond_input_three_in(p3_pin), .cond_input_two_in(p2_pin), .*);
   cbc_mem_model #(.WORD_BASE(WORD_BASE)) cbc_mem_model_inst (.*);
   always #4 clk_sys = ~clk_sys;
   ////////////////////////////////////////
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_sig(input logic sel, input logic v);
      for (int i = 0; i < 20 && (sel ? bus_out_en : external_master_grant) !== v; i++) step();
   endtask
   // One whole transfer; n is the datum count the bus must show
   task automatic xfer(input logic w, im, dm, input logic [31:0] a, input cbc_cnt_t nc,
         input logic fl_n, input int n);
      int i, k, s;
      logic lst;
      @(negedge clk_sys);
      {req_valid, req_write, req_icache_miss, req_dcache_miss} = {1'h1, w, im, dm};
      req_addr = a;
      req_narrow_cnt = nc;
      for (i = 0; i < 50 && req_taken !== 1'h1; i++) step();
      check(burst_near_n, fl_n);
      check({rd_n, wr_n}, {w, !w});
      @(negedge clk_sys);
      req_valid = 1'h0;
      k = 0;
      s = 0;
      lst = 1'h1;
      io_seen = 1'h0;
      for (i = 0; i < 200 && xfer_done !== 1'h1; i++) begin
         step();
         io_seen |= cond_input_three_out;
         if (lst === 1'h1 && per_datum_strobe_n === 1'h0) s++;
         lst = per_datum_strobe_n;
         if (read_buffer_valid === 1'h1) begin
            check(read_buffer_data, exp_word);
            exp_word++;
            k++;
         end
      end
      // Held while the indicator is already back high, gone one cycle later
      ext_tail = cond_input_two_out & rd_n & wr_n;
      check(xfer_done, 1'h1);
      check(s, n);
      check(k, w ? 0 : n);
      step();
      ext_tail &= !cond_input_two_out;
   endtask
   ////////////////////////////////////////
   task automatic t_reads();
      xfer(1'h0, 1'h0, 1'h0, 32'h0000_1000, 2'h0, 1'h1, 1);
      xfer(1'h0, 1'h1, 1'h0, 32'h0000_2000, 2'h1, 1'h0, 4);
      xfer(1'h0, 1'h0, 1'h1, 32'h0000_3000, 2'h0, 1'h1, 1);
      @(negedge clk_sys);
      cfg_dcache_refill4 = 1'h1;
      wait_cycles = 4'h5;
      xfer(1'h0, 1'h0, 1'h1, 32'h0000_4000, 2'h0, 1'h0, 4);
      wait_cycles = 4'h0;
      $display("test reads done");
   endtask
   task automatic t_writes();
      xfer(1'h1, 1'h0, 1'h0, 32'h0000_10fc, 2'h1, 1'h1, 2);
      xfer(1'h1, 1'h0, 1'h0, 32'h0000_1000, 2'h0, 1'h0, 1);
      xfer(1'h1, 1'h0, 1'h0, 32'h0000_1100, 2'h0, 1'h1, 1);
      xfer(1'h0, 1'h0, 1'h0, 32'h0000_1104, 2'h0, 1'h1, 1);
      xfer(1'h1, 1'h0, 1'h0, 32'h0000_1108, 2'h0, 1'h1, 1);
      $display("test writes done");
   endtask
   task automatic t_pins();
      for (int p = 0; p < 4; p++) begin
         @(negedge clk_sys);
         {drv3, drv2} = p[1:0];
         repeat (4) step();
         check(coprocessor_condition, p[1:0]);
      end
      @(negedge clk_sys);
      {cfg_pin3_strobe_mode, cfg_pin2_strobe_mode, cfg_io_strobe_rd, cfg_ext_en_rd} = 4'hf;
      xfer(1'h0, 1'h0, 1'h0, 32'h0000_5000, 2'h0, 1'h1, 1);
      check({cond_input_three_oe, cond_input_two_oe, coprocessor_condition}, 4'hc);
      check({io_seen, ext_tail}, 2'h3);
      // Write strobes left off: neither pin may fire on a write
      xfer(1'h1, 1'h0, 1'h0, 32'h0000_5004, 2'h0, 1'h1, 1);
      check({io_seen, ext_tail}, 2'h0);
      @(negedge clk_sys);
      {cfg_io_strobe_wr, cfg_ext_en_wr} = 2'h3;
      xfer(1'h1, 1'h0, 1'h0, 32'h0000_5008, 2'h0, 1'h0, 1);
      check({io_seen, ext_tail}, 2'h3);
      $display("test pins done");
   endtask
   task automatic t_dma();
      @(negedge clk_sys);
      {core_reclaim, external_master_request} = 2'h3;
      wait_sig(1'h0, 1'h1);
      repeat (3) step();
      // Reclaim disabled: the core's wish must not take the bus back
      check({external_master_grant, bus_out_en}, 2'h2);
      @(negedge clk_sys);
      {core_reclaim, external_master_request} = 2'h0;
      wait_sig(1'h1, 1'h1);
      check({external_master_grant, bus_out_en}, 2'h1);
      @(negedge clk_sys);
      {cfg_early_reclaim_en, external_master_request} = 2'h3;
      wait_sig(1'h0, 1'h1);
      @(negedge clk_sys);
      core_reclaim = 1'h1;
      wait_sig(1'h0, 1'h0);
      repeat (3) step();
      check({external_master_grant, bus_out_en}, 2'h0);
      @(negedge clk_sys);
      {core_reclaim, external_master_request} = 2'h0;
      wait_sig(1'h1, 1'h1);
      check({external_master_grant, bus_out_en}, 2'h1);
      xfer(1'h0, 1'h0, 1'h0, 32'h0000_6000, 2'h0, 1'h1, 1);
      $display("test arbitration done");
   endtask
   task automatic t_reset();
      @(negedge clk_sys);
      rstn = 1'h0;
      step();
      check({rd_n, wr_n, burst_near_n, per_datum_strobe_n, bus_out_en, external_master_grant,
         system_reference_clock, req_taken, xfer_done}, 9'h1f0);
      @(negedge clk_sys);
      rstn = 1'h1;
      step();
      check(system_reference_clock, 1'h1);
      step();
      check(system_reference_clock, 1'h0);
      xfer(1'h0, 1'h0, 1'h0, 32'h0000_7000, 2'h0, 1'h1, 1);
      $display("test reset done");
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      rstn = 1'h1;
      t_reads();
      t_writes();
      t_pins();
      t_dma();
      t_reset();
      summarize();
   end
   // Whole run needs well under 2000 cycles
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
endmodule
